// ---- src/fci_host.sv ----
// host controller that sequences flash command cycles on the parallel pins
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Host writes identifier command then performs two reads for both codes.
// - Lock indications read locked at power-up until host issues upload and confirm.
// - Two-byte write in byte width; first address bit picks order, inverted second.
// - Host always writes zero as the high byte of a buffer count.
// - Sequential buffer load: command, low count, high count; no address/data pairs follow.
// - Buffer-to-array write destination address matches the buffer source location.
// - Host confirms completion by ready status bit before returning status in OP_WAIT only; OP_STATUS returns a single read.
module fci_host
   import fci_pkg::*;
#(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
) (
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire fci_op_t           cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_data,
   input  wire logic              cmd_word,
   input  wire logic              pd_req,
   output logic                   busy,
   output logic                   device_ready,
   output logic                   rd_valid,
   input  wire logic              rd_ready,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   ce0_n,
   output logic                   ce1_n,
   output logic                   oe_n,
   output logic                   we_n,
   output logic                   byte_n,
   output logic                   powerdown_reset_n,
   output logic [ADDR_W-1:0]      addr,
   output logic [DATA_W-1:0]      dq_o,
   output logic                   dq_oe_n,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic              ready_busy_n
);

   if (ADDR_W != 21 || DATA_W != 16) begin : g_bad_width
      $error("fci_host serves only a 21-bit address and 16-bit data");
   end

   typedef enum {S_IDLE, S_STEP, S_WR_SETUP, S_WR_LOW, S_WR_HOLD, S_RD_WAIT, S_RD_CAP, S_PD, S_RECOVER} fci_state_t;

   fci_state_t  state_q;
   fci_op_t     op_q;
   logic [20:0] op_addr_q;
   logic [15:0] op_data_q;
   logic        op_word_q;
   logic [2:0]  step_q;
   logic [7:0]  cnt_q;
   logic [20:0] pin_addr_q;
   logic [15:0] pin_dout_q;
   logic [15:0] dq_meta_q;
   logic [15:0] dq_sync_q;
   logic        rb_meta_q;
   logic        rb_sync_q;
   logic [15:0] buf_mem_q [0:1];
   logic        buf_wptr_q;
   logic        buf_rptr_q;
   logic [1:0]  buf_cnt_q;
   fci_step_t   st;
   logic        buf_full;
   logic        push;
   logic        pop;

   function automatic fci_step_t wr(input logic [20:0] a, input logic [7:0] hi, input logic [7:0] lo);
      return '{K_WR, a, {hi, lo}};
   endfunction : wr

   function automatic fci_step_t cmd(input logic [7:0] c);
      return '{K_WR, 21'h000000, {8'h00, c}};
   endfunction : cmd

   // byte-wide pair: first lane chosen by address bit 0, second at flipped address
   function automatic fci_step_t pair(input logic second, input logic [20:0] a, input logic [7:0] hi,
                                      input logic [7:0] lo);
      logic [7:0] first_b;
      logic [7:0] other_b;
      first_b = a[0] ? hi : lo;
      other_b = a[0] ? lo : hi;
      return second ? wr(a ^ BYTE_FLIP, 8'h00, other_b) : wr(a, 8'h00, first_b);
   endfunction : pair

   function automatic fci_step_t step_of(input fci_op_t op, input logic [2:0] s, input logic [20:0] a,
                                         input logic [15:0] d, input logic w);
      fci_step_t r;
      r = '{K_END, 21'h000000, 16'h0000};
      case (op)
         OP_WRITE:     if (s == 3'd0) r = '{K_WR, a, d};
         OP_READ:      if (s == 3'd0) r = '{K_RD, a, 16'h0000};
         OP_READ_ID: begin
            if (s == 3'd0) r = cmd(CMD_READ_ID);
            else if (s == 3'd1) r = '{K_RD, ID_ADDR_LOW, 16'h0000};
            else if (s == 3'd2) r = '{K_RD, w ? ID_ADDR_HIGH_WORD : ID_ADDR_HIGH_BYTE, 16'h0000};
         end
         OP_STATUS: begin
            if (s == 3'd0) r = cmd(CMD_READ_STATUS);
            else if (s == 3'd1) r = '{K_RD, 21'h000000, 16'h0000};
         end
         OP_WAIT: begin
            if (s == 3'd0) r = cmd(CMD_READ_STATUS);
            else if (s == 3'd1) r = '{K_POLL, 21'h000000, 16'h0000};
         end
         OP_CLEAR:     if (s == 3'd0) r = cmd(CMD_CLEAR);
         OP_UPLOAD: begin
            if (s == 3'd0) r = cmd(CMD_UPLOAD);
            else if (s == 3'd1) r = cmd(CMD_CONFIRM);
         end
         OP_DEVINFO: begin
            if (s == 3'd0) r = cmd(CMD_DEVINFO);
            else if (s == 3'd1) r = cmd(CMD_CONFIRM);
         end
         OP_ERASE_ALL: begin
            if (s == 3'd0) r = cmd(CMD_ERASE_ALL);
            else if (s == 3'd1) r = cmd(CMD_CONFIRM);
         end
         OP_SWAP:      if (s == 3'd0) r = cmd(CMD_SWAP);
         OP_SLEEP:     if (s == 3'd0) r = cmd(CMD_SLEEP);
         OP_ABORT:     if (s == 3'd0) r = cmd(CMD_ABORT);
         OP_RDY_CFG: begin
            // out-of-range modes are dropped without any bus cycle
            if (d[7:0] >= RDY_MODE_MIN && d[7:0] <= RDY_MODE_MAX) begin
               if (s == 3'd0) r = cmd(CMD_RDY_CFG);
               else if (s == 3'd1) r = wr(21'h000000, 8'h00, d[7:0]);
            end
         end
         OP_LOAD_SEQ: begin
            if (s == 3'd0) r = cmd(CMD_LOAD_SEQ);
            else if (s == 3'd1) r = wr(21'h000000, 8'h00, d[7:0]);
            else if (s == 3'd2) r = wr(21'h000000, 8'h00, COUNT_HIGH);
         end
         OP_BUF_WRITE: begin
            if (s == 3'd0) r = cmd(CMD_BUF_WRITE);
            else if (s <= 3'd2 && !w) r = pair(s == 3'd2, a, COUNT_HIGH, d[7:0]);
            else if (s == 3'd1) r = wr(a, 8'h00, d[7:0]);
            else if (s == 3'd2) r = wr(a, 8'h00, COUNT_HIGH);
         end
         OP_TWO_BYTE: begin
            if (s == 3'd0) r = cmd(CMD_TWO_BYTE);
            else if (s <= 3'd2) r = pair(s == 3'd2, a, d[15:8], d[7:0]);
         end
         default: r = '{K_END, 21'h000000, 16'h0000};
      endcase
      return r;
   endfunction : step_of

   assign st       = step_of(op_q, step_q, op_addr_q, op_data_q, op_word_q);
   assign buf_full = (buf_cnt_q == 2'd2);
   assign push     = (state_q == S_RD_CAP) && (st.kind == K_RD || dq_sync_q[LOS_READY_BIT]);
   assign pop      = rd_valid && rd_ready;

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers
   always_ff @(posedge clock) begin
      if (!resetn) begin
         dq_meta_q <= 16'h0000;
         dq_sync_q <= 16'h0000;
         rb_meta_q <= 1'b0;
         rb_sync_q <= 1'b0;
      end else begin
         dq_meta_q <= dq_i;
         dq_sync_q <= dq_meta_q;
         rb_meta_q <= ready_busy_n;
         rb_sync_q <= rb_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q    <= S_RECOVER;
         cnt_q      <= 8'(RECOVER_CYC - 1);
         op_q       <= OP_WRITE;
         op_addr_q  <= 21'h000000;
         op_data_q  <= 16'h0000;
         op_word_q  <= 1'b0;
         step_q     <= 3'd0;
         pin_addr_q <= 21'h000000;
         pin_dout_q <= 16'h0000;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (pd_req) begin
                  state_q <= S_PD;
               end else if (cmd_valid) begin
                  op_q      <= cmd_op;
                  op_addr_q <= cmd_addr;
                  op_data_q <= cmd_data;
                  op_word_q <= cmd_word && (cmd_op != OP_TWO_BYTE);
                  step_q    <= 3'd0;
                  state_q   <= S_STEP;
               end
            end
            S_STEP: begin
               pin_addr_q <= st.addr;
               pin_dout_q <= st.data;
               if (st.kind == K_END) begin
                  state_q <= S_IDLE;
               end else if (st.kind == K_WR) begin
                  cnt_q   <= 8'(SETUP_CYC - 1);
                  state_q <= S_WR_SETUP;
               end else if (!buf_full) begin
                  cnt_q   <= 8'(READ_CYC - 1);
                  state_q <= S_RD_WAIT;
               end
            end
            S_WR_SETUP: begin
               if (cnt_q == 8'h00) begin
                  cnt_q   <= 8'(WE_LOW_CYC - 1);
                  state_q <= S_WR_LOW;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_WR_LOW: begin
               if (cnt_q == 8'h00) begin
                  cnt_q   <= 8'(WE_HOLD_CYC - 1);
                  state_q <= S_WR_HOLD;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_WR_HOLD: begin
               if (cnt_q == 8'h00) begin
                  step_q  <= step_q + 3'd1;
                  state_q <= S_STEP;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            S_RD_WAIT: begin
               if (cnt_q == 8'h00) state_q <= S_RD_CAP;
               else cnt_q <= cnt_q - 8'h01;
            end
            S_RD_CAP: begin
               if (st.kind == K_RD || dq_sync_q[LOS_READY_BIT]) step_q <= step_q + 3'd1;
               state_q <= S_STEP;
            end
            S_PD: begin
               if (!pd_req) begin
                  cnt_q   <= 8'(RECOVER_CYC - 1);
                  state_q <= S_RECOVER;
               end
            end
            S_RECOVER: begin
               if (cnt_q == 8'h00) state_q <= S_IDLE;
               else cnt_q <= cnt_q - 8'h01;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-entry read data buffer
   always_ff @(posedge clock) begin
      if (!resetn) begin
         buf_mem_q[0] <= 16'h0000;
         buf_mem_q[1] <= 16'h0000;
         buf_wptr_q   <= 1'b0;
         buf_rptr_q   <= 1'b0;
         buf_cnt_q    <= 2'd0;
      end else begin
         if (push) begin
            buf_mem_q[buf_wptr_q] <= dq_sync_q;
            buf_wptr_q            <= ~buf_wptr_q;
         end
         if (pop) buf_rptr_q <= ~buf_rptr_q;
         if (push && !pop) buf_cnt_q <= buf_cnt_q + 2'd1;
         else if (pop && !push) buf_cnt_q <= buf_cnt_q - 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin and user outputs
   assign rd_valid          = (buf_cnt_q != 2'd0);
   assign rd_data           = buf_mem_q[buf_rptr_q];
   assign cmd_ready         = (state_q == S_IDLE) && !pd_req;
   assign busy              = (state_q != S_IDLE);
   assign device_ready      = rb_sync_q;
   assign ce0_n             = !(state_q inside {S_WR_SETUP, S_WR_LOW, S_WR_HOLD, S_RD_WAIT, S_RD_CAP});
   assign ce1_n             = ce0_n;
   assign oe_n              = !(state_q inside {S_RD_WAIT, S_RD_CAP});
   assign we_n              = (state_q != S_WR_LOW);
   assign dq_oe_n           = !(state_q inside {S_WR_SETUP, S_WR_LOW, S_WR_HOLD});
   assign byte_n            = op_word_q;
   // pin low in the power-down state, entered from idle on request, or while reset holds
   assign powerdown_reset_n = (state_q != S_PD) && resetn;
   assign addr              = pin_addr_q;
   assign dq_o              = pin_dout_q;

endmodule : fci_host

`default_nettype wire

// ---- include/fci_pkg.sv ----
// constants, opcodes and types for the flash command host controller
package fci_pkg;

   localparam int CLK_PERIOD_NS  = 10;
   localparam int T_ACC_NS       = 80;
   localparam int T_SETUP_NS     = 10;
   localparam int T_WE_LOW_NS    = 50;
   localparam int T_WE_HOLD_NS   = 30;
   localparam int T_RECOVER_NS   = 500;
   localparam int SYNC_STAGES    = 2;

   // least times round up to whole cycles, never below one
   function automatic int fci_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : fci_cyc

   localparam int SETUP_CYC   = fci_cyc(T_SETUP_NS);
   localparam int WE_LOW_CYC  = fci_cyc(T_WE_LOW_NS);
   localparam int WE_HOLD_CYC = fci_cyc(T_WE_HOLD_NS);
   localparam int READ_CYC    = fci_cyc(T_ACC_NS) + SYNC_STAGES;
   localparam int RECOVER_CYC = fci_cyc(T_RECOVER_NS);

   localparam logic [7:0] CMD_READ_ID     = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR       = 8'h50;
   localparam logic [7:0] CMD_UPLOAD      = 8'h97;
   localparam logic [7:0] CMD_DEVINFO     = 8'h99;
   localparam logic [7:0] CMD_ERASE_ALL   = 8'ha7;
   localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
   localparam logic [7:0] CMD_SWAP        = 8'h72;
   localparam logic [7:0] CMD_SLEEP       = 8'hf0;
   localparam logic [7:0] CMD_ABORT       = 8'h80;
   localparam logic [7:0] CMD_RDY_CFG     = 8'h96;
   localparam logic [7:0] CMD_LOAD_SEQ    = 8'he0;
   localparam logic [7:0] CMD_BUF_WRITE   = 8'h0c;
   localparam logic [7:0] CMD_TWO_BYTE    = 8'hfb;
   localparam logic [7:0] COUNT_HIGH      = 8'h00;
   localparam logic [7:0] RDY_MODE_MIN    = 8'h01;
   localparam logic [7:0] RDY_MODE_MAX    = 8'h05;

   // legacy_operation_status field positions
   localparam int LOS_READY_BIT     = 7;
   localparam int LOS_SUSPENDED_BIT = 6;
   localparam int LOS_ERASE_ERR_BIT = 5;
   localparam int LOS_PROG_ERR_BIT  = 4;
   localparam int LOS_SUPPLY_BIT    = 3;

   localparam logic [20:0] ID_ADDR_LOW       = 21'h000000;
   localparam logic [20:0] ID_ADDR_HIGH_BYTE = 21'h000001;
   localparam logic [20:0] ID_ADDR_HIGH_WORD = 21'h000002;
   localparam logic [20:0] BYTE_FLIP         = 21'h000001;

   typedef enum logic [3:0] {
      OP_WRITE, OP_READ, OP_READ_ID, OP_STATUS, OP_WAIT, OP_CLEAR, OP_UPLOAD, OP_DEVINFO,
      OP_ERASE_ALL, OP_SWAP, OP_SLEEP, OP_ABORT, OP_RDY_CFG, OP_LOAD_SEQ, OP_BUF_WRITE, OP_TWO_BYTE
   } fci_op_t;

   typedef enum logic [1:0] {K_END, K_WR, K_RD, K_POLL} fci_kind_t;

   typedef struct packed {
      fci_kind_t   kind;
      logic [20:0] addr;
      logic [15:0] data;
   } fci_step_t;

endpackage : fci_pkg

// ---- testbench/fci_host_assertions.sv ----
// concurrent checks on the flash host controller pins and handshakes
`timescale 1ns/100ps
`default_nettype none
module fci_host_assertions #(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
) (
   input wire logic              clock,
   input wire logic              resetn,
   input wire logic              cmd_valid,
   input wire logic              cmd_ready,
   input wire logic              pd_req,
   input wire logic              busy,
   input wire logic              device_ready,
   input wire logic              ce0_n,
   input wire logic              ce1_n,
   input wire logic              oe_n,
   input wire logic              we_n,
   input wire logic              powerdown_reset_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic              dq_oe_n,
   input wire logic              ready_busy_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence we_pulse_s; !we_n [*5] ##1 we_n; endsequence
   sequence read_s; (!oe_n && !ce0_n && !ce1_n && dq_oe_n) [*8]; endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_we_width: assert property ($fell(we_n) |-> we_pulse_s) else $error("write pulse width");
   chk_we_setup: assert property ($fell(we_n) |-> !$past(ce0_n) && !dq_oe_n && oe_n) else $error("write setup");
   chk_data_hold: assert property ($rose(we_n) |-> !ce0_n && !dq_oe_n && $stable(addr) && $stable(dq_o))
      else $error("write hold");
   chk_read_len: assert property ($fell(oe_n) |-> read_s) else $error("read access");
   chk_pd_enter: assert property (pd_req && !busy |=> !powerdown_reset_n) else $error("powerdown entry");
   chk_pd_quiet: assert property (!powerdown_reset_n |-> we_n && oe_n && dq_oe_n) else $error("powerdown bus");
   chk_recover_wait: assert property ($rose(powerdown_reset_n) |-> !cmd_ready [*8]) else $error("recovery");
   chk_take_busy: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready) else $error("accept");
   chk_ready_sync: assert property ($fell(ready_busy_n) |-> ##[1:3] !device_ready) else $error("ready sync");
endmodule : fci_host_assertions
`default_nettype wire

// ---- testbench/fci_flash_model.sv ----
// behavioural flash device answering the host controller pins
`timescale 1ns/100ps
`default_nettype none
module fci_flash_model #(
   parameter logic [15:0] MAKER_CODE  = 16'h0012, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0034, // arbitrary value
   parameter int          ERASE_CYC   = 300
) (
   input  wire logic        clock,
   input  wire logic        ce0_n,
   input  wire logic        ce1_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        byte_n,
   input  wire logic        powerdown_reset_n,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] dq_o,
   input  wire logic        supply_ok,
   output logic [15:0]      dq_i,
   output logic             ready_busy_n
);
   logic [7:0]  cmd_q = 8'h00;
   logic [1:0]  mode_q = 2'd0;
   logic [5:3]  err_q = 3'b000;
   logic        we_q = 1'b1;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] rd_val;
   int          busy_cnt = 0;
   logic [1:0]  load_ph = 2'd0;
   int          load_len = 0;
   int          fill_left = 0;
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      we_q <= we_n;
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (!powerdown_reset_n) begin
         mode_q <= 2'd0;
         err_q <= 3'b000;
         busy_cnt <= 0;
         cmd_q <= 8'h00;
         load_ph <= 2'd0;
         fill_left <= 0;
      end else if (!ce0_n && !ce1_n && we_n && !we_q) begin
         // count from low lines plus one, then that many data cycles
         if (load_ph != 2'd0 || fill_left > 0) begin
            if (load_ph == 2'd1) load_len <= int'(dq_o[7:0]) + 1;
            if (load_ph == 2'd2) fill_left <= load_len;
            else if (fill_left > 0) fill_left <= fill_left - 1;
            load_ph <= (load_ph == 2'd1) ? 2'd2 : 2'd0;
         end else begin
            cmd_q <= dq_o[7:0];
            case (dq_o[7:0])
               8'h90: mode_q <= 2'd1;
               8'h70: mode_q <= 2'd2;
               8'h71: mode_q <= 2'd2;
               8'he0: load_ph <= 2'd1;
               8'hff: mode_q <= 2'd0;
               8'h50: err_q <= 3'b000;
               8'h80: busy_cnt <= 0;
               8'hd0: if (cmd_q == 8'ha7) begin
                  mode_q <= 2'd2;
                  if (supply_ok) busy_cnt <= ERASE_CYC;
                  else err_q <= 3'b101;
               end
               default: ;
            endcase
         end
      end
      ready_busy_n <= !powerdown_reset_n || busy_cnt == 0;
      last_q <= dq_i;
   end
   always_comb begin
      case (mode_q)
         2'd1: rd_val = (byte_n ? addr[1] : addr[0]) ? DEVICE_CODE : MAKER_CODE;
         2'd2: rd_val = {8'h00, busy_cnt == 0, 1'b0, err_q, 3'b000};
         default: rd_val = byte_n ? addr[16:1] : {8'h00, addr[7:0]};
      endcase
      if (!byte_n) rd_val[15:8] = ~last_q[15:8];
      dq_i = (!ce0_n && !ce1_n && !oe_n && powerdown_reset_n) ? rd_val : ~last_q;
   end
endmodule : fci_flash_model
`default_nettype wire

// ---- testbench/tb_fci_host.sv ----
// self-checking bench for the flash command host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_fci_host;
   import fci_pkg::*;
   localparam logic [15:0] MK = 16'h0012; // arbitrary value
   localparam logic [15:0] DV = 16'h0034; // arbitrary value
   logic        clock, resetn, cmd_valid, cmd_ready, cmd_word, pd_req, busy, device_ready;
   logic        rd_valid, rd_ready, ce0_n, ce1_n, oe_n, we_n, byte_n, powerdown_reset_n;
   logic        dq_oe_n, ready_busy_n, supply_ok, wb;
   logic [20:0] cmd_addr, addr, ra;
   logic [15:0] cmd_data, rd_data, dq_o, dq_i;
   fci_op_t     cmd_op;
   int          mismatches, tests_run, seed;
   fci_op_t     misc[7] = '{OP_UPLOAD, OP_DEVINFO, OP_SWAP, OP_SLEEP, OP_LOAD_SEQ, OP_BUF_WRITE, OP_TWO_BYTE};
   fci_host fci_host_i (.clock, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_word,
      .pd_req, .busy, .device_ready, .rd_valid, .rd_ready, .rd_data, .ce0_n, .ce1_n, .oe_n, .we_n, .byte_n,
      .powerdown_reset_n, .addr, .dq_o, .dq_oe_n, .dq_i, .ready_busy_n);
   fci_flash_model #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) fci_flash_model_i (.clock, .ce0_n, .ce1_n, .oe_n,
      .we_n, .byte_n, .powerdown_reset_n, .addr, .dq_o, .supply_ok, .dq_i, .ready_busy_n);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] exp_arr(input logic [20:0] a, input logic w);
      return w ? a[16:1] : {8'h00, a[7:0]};
   endfunction : exp_arr
   task automatic wrap_up();
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   // selects read data valid when on_data is set, command ready otherwise
   task automatic wait_for(input bit on_data, input int lim);
      int   n;
      logic s;
      n = 0;
      s = 1'b0;
      do begin
         @(posedge clock);
         n++;
         s = on_data ? rd_valid : cmd_ready;
      end while (s !== 1'b1 && n < lim);
      if (s !== 1'b1) begin
         mismatches++;
         $display("mismatch handshake timeout expected 1 seen %b", s);
         wrap_up();
      end
   endtask : wait_for
   task automatic issue(input fci_op_t op, input logic [20:0] a, input logic [15:0] d, input logic w);
      @(posedge clock);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_word <= w;
      cmd_valid <= 1'b1;
      wait_for(1'b0, 3000);
      cmd_valid <= 1'b0;
   endtask : issue
   task automatic pop(input logic [15:0] e, input logic w, input string nm);
      @(posedge clock);
      rd_ready <= 1'b1;
      wait_for(1'b1, 3000);
      rd_ready <= 1'b0;
      `CHK(nm, rd_data & (w ? 16'hffff : 16'h00ff), e)
   endtask : pop
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {mismatches, tests_run, seed} = {32'd0, 32'd0, 32'd35};
      {resetn, cmd_valid, cmd_word, pd_req, rd_ready, supply_ok, wb} = 7'b0000010;
      cmd_op = OP_READ;
      {cmd_addr, cmd_data, ra} = {21'h0, 16'h0, 21'h0};
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      for (int w = 0; w < 2; w++) begin
         issue(OP_READ_ID, 21'h0, 16'h0, w[0]);
         wait_for(1'b0, 3000);
         pop(w ? MK : {8'h00, MK[7:0]}, w[0], "maker code");
         pop(w ? DV : {8'h00, DV[7:0]}, w[0], "device code");
      end
      $display("test identifier done");
      issue(OP_WRITE, 21'h0, 16'h00ff, 1'b1);
      for (int i = 0; i < 6; i++) begin
         ra = 21'($random(seed));
         wb = 1'($random(seed));
         issue(OP_READ, ra, 16'h0, wb);
         pop(exp_arr(ra, wb), wb, "array word");
      end
      $display("test array read done");
      supply_ok <= 1'b0;
      issue(OP_ERASE_ALL, 21'h0, 16'h0, 1'b0);
      issue(OP_STATUS, ra, 16'h0, 1'b0);
      supply_ok <= 1'b1;
      pop(16'h00a8, 1'b0, "failed erase status");
      issue(OP_CLEAR, 21'h0, 16'h0, 1'b0);
      issue(OP_STATUS, 21'h0, 16'h0, 1'b0);
      pop(16'h0080, 1'b0, "cleared status");
      $display("test status errors done");
      issue(OP_ERASE_ALL, 21'h0, 16'h0, 1'b0);
      issue(OP_READ, ra, 16'h0, 1'b0);
      pop(16'h0000, 1'b0, "busy status");
      `CHK("ready pin busy", device_ready, 1'b0)
      issue(OP_WAIT, 21'h0, 16'h0, 1'b0);
      pop(16'h0080, 1'b0, "erase done status");
      `CHK("ready pin idle", device_ready, 1'b1)
      issue(OP_ERASE_ALL, 21'h0, 16'h0, 1'b0);
      issue(OP_ABORT, 21'h0, 16'h0, 1'b0);
      issue(OP_STATUS, 21'h0, 16'h0, 1'b0);
      pop(16'h0080, 1'b0, "aborted status");
      $display("test erase done");
      supply_ok <= 1'b0;
      issue(OP_ERASE_ALL, 21'h0, 16'h0, 1'b0);
      wait_for(1'b0, 3000);
      supply_ok <= 1'b1;
      issue(OP_ERASE_ALL, 21'h0, 16'h0, 1'b0);
      wait_for(1'b0, 3000);
      @(posedge clock);
      `CHK("ready pin erasing", device_ready, 1'b0)
      pd_req <= 1'b1;
      repeat (6) @(posedge clock);
      `CHK("powerdown pin", powerdown_reset_n, 1'b0)
      `CHK("ready pin powerdown", device_ready, 1'b1)
      pd_req <= 1'b0;
      issue(OP_READ, ra, 16'h0, 1'b1);
      pop(exp_arr(ra, 1'b1), 1'b1, "array after powerdown");
      issue(OP_STATUS, 21'h0, 16'h0, 1'b0);
      pop(16'h0080, 1'b0, "status after powerdown");
      $display("test powerdown done");
      for (int m = 0; m < 7; m++) issue(OP_RDY_CFG, 21'h0, 16'(m), 1'b0);
      foreach (misc[i]) issue(misc[i], 21'h0, 16'h0005, 1'b0);
      issue(OP_STATUS, 21'h0, 16'h0, 1'b0);
      pop(16'h0080, 1'b0, "status after command set");
      $display("test command set done");
      wrap_up();
   end
endmodule : tb_fci_host
bind fci_host fci_host_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.clock, .resetn, .cmd_valid,
   .cmd_ready, .pd_req, .busy, .device_ready, .ce0_n, .ce1_n, .oe_n, .we_n, .powerdown_reset_n, .addr, .dq_o,
   .dq_oe_n, .ready_busy_n);
`default_nettype wire
